//--- include/lrg_defs.svh
// constants for the logic rule gate and delay block
`ifndef LRG_DEFS_SVH
`define LRG_DEFS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define LRG_OFS_CTRL     12'h000
`define LRG_OFS_PERIOD   12'h004
`define LRG_OFS_CUSTOM   12'h008
`define LRG_OFS_STATUS   12'h00C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define LRG_CTRL_RUN     0
`define LRG_CTRL_OP_LO   1
`define LRG_CTRL_OP_HI   2
`define LRG_CTRL_CHAIN   3
`define LRG_CTRL_EN_LO   4
`define LRG_CTRL_EN_HI   6
`define LRG_CTRL_PREV    7
`define LRG_CTRL_OSL_LO  8
`define LRG_CTRL_OSL_HI  10
`define LRG_PER_SEL_HI   2
`define LRG_CUST_HI      15

// ----------------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------------
`define LRG_CTRL_RST     11'h000
`define LRG_PER_RST      3'h0
`define LRG_CUST_RST     16'h0001
`define LRG_CLK_HZ       125000000
`define LRG_MS_PER_S     1000
`define LRG_CYC_PER_MS   (`LRG_CLK_HZ / `LRG_MS_PER_S)

// ----------------------------------------------------------------------------
// predefined execution periods in ms
// ----------------------------------------------------------------------------
`define LRG_PER_MS_1     16'h0001
`define LRG_PER_MS_2     16'h000A
`define LRG_PER_MS_3     16'h0064
`define LRG_PER_MS_4     16'h03E8
`define LRG_PER_MS_5     16'h2710
`define LRG_PER_MS_6     16'hEA60

`endif

//--- include/lrg_pkg.sv
// types shared by the logic rule gate and delay block
package lrg_pkg;

    // gate operation selector
    typedef enum logic [1:0]
    {
        LRG_OP_AND  = 2'h0,
        LRG_OP_OR   = 2'h1,
        LRG_OP_NAND = 2'h2,
        LRG_OP_NOR  = 2'h3
    } lrg_op_t;

    // execution stage states, gray along halt -> wait -> fire
    typedef enum logic [1:0]
    {
        LRG_ST_HALT = 2'h0,
        LRG_ST_WAIT = 2'h1,
        LRG_ST_FIRE = 2'h3
    } lrg_state_t;

    // software configuration of one rule
    typedef struct packed
    {
        logic [2:0]  out_slot_en;  // output slots in use
        logic        prev_in;      // input slot 2 takes previous rule
        logic [2:0]  in_en;        // configured input slots
        logic        chain;        // 1: next-rule mode, 0: delayed
        lrg_op_t     op;           // gate operation
        logic        run;          // engine running
    } lrg_cfg_t;

endpackage : lrg_pkg

//--- design/lrg_rule.sv
// one logic rule: gate stage, execution stage and apb registers
`timescale 1ns/10ps
`include "lrg_defs.svh"

module lrg_rule
#(
    parameter int CYC_PER_MS = `LRG_CYC_PER_MS  // clock cycles in one millisecond
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [2:0]  cond_in,
    input  wire logic        prev_rule_in,
    output logic             chain_to_following_rule,
    output logic             exec_result,
    output logic             exec_strobe,
    output logic [2:0]       slot_result,
    output logic [2:0]       slot_active,
    output logic             slot_is_link
);

    // ------------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------------
    localparam int PW = 17;  // prescaler width

    // prescaler must fit its counter and count at least one cycle
    if (CYC_PER_MS < 1 || CYC_PER_MS >= (1 << PW))
    begin : g_bad_param
        $error("CYC_PER_MS out of range");
    end

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    lrg_pkg::lrg_cfg_t    cfg_q,      cfg_d;       // control register
    logic [2:0]           per_q,      per_d;       // period selector
    logic [15:0]          cust_q,     cust_d;      // custom period in ms
    logic [31:0]          prdata_q,   prdata_d;    // read data
    logic                 pready_q,   pready_d;    // access answer
    logic                 pslverr_q,  pslverr_d;   // unmapped access
    lrg_pkg::lrg_state_t  st_q,       st_d;        // execution state
    logic [PW-1:0]        pre_q,      pre_d;       // ms prescaler
    logic [15:0]          ms_q,       ms_d;        // ms left in period
    logic                 res_q,      res_d;       // result to output stage
    logic                 stb_q,      stb_d;       // one-cycle delivery pulse
    logic                 chn_q,      chn_d;       // result to following rule
    logic [2:0]           sres_q,     sres_d;      // per-slot result
    logic [2:0]           sact_q,     sact_d;      // per-slot active
    logic                 link_q,     link_d;      // slot 0 holds the link
    logic [2:0]           cond_eff;                // inputs after chain select
    logic                 all_true;                // every used input true
    logic                 any_true;                // some used input true
    logic                 gate_res;                // gate stage result
    logic                 ms_tick;                 // one millisecond passed
    logic                 full_speed;              // no intentional delay
    logic [15:0]          per_ms;                  // selected period in ms
    logic                 wr_acc;                  // completed write
    logic [11:0]          acc_addr;                // word aligned address

    // ------------------------------------------------------------------------
    // gate stage
    // ------------------------------------------------------------------------

    // input slot 2 may carry the previous rule's chained result
    always_comb
    begin
        cond_eff = cond_in;
        if (cfg_q.prev_in)
        begin
            cond_eff[2] = prev_rule_in;
        end
    end

    // unused slots drop out: neutral true for and, neutral false for or
    always_comb
    begin
        all_true = &(cond_eff | ~cfg_q.in_en);
        any_true = |(cond_eff & cfg_q.in_en);
        case (cfg_q.op)
            lrg_pkg::LRG_OP_AND:  gate_res = all_true;
            lrg_pkg::LRG_OP_OR:   gate_res = any_true;
            lrg_pkg::LRG_OP_NAND: gate_res = ~all_true;
            lrg_pkg::LRG_OP_NOR:  gate_res = ~any_true;
            default:              gate_res = 1'b0;
        endcase
    end

    // ------------------------------------------------------------------------
    // period selection
    // ------------------------------------------------------------------------

    // predefined periods, custom value, or full speed
    always_comb
    begin
        full_speed = 1'b0;
        per_ms     = `LRG_PER_MS_1;                  // shortest period unless chosen
        case (per_q)
            3'h0:    full_speed = 1'b1;
            3'h1:    per_ms = `LRG_PER_MS_1;
            3'h2:    per_ms = `LRG_PER_MS_2;
            3'h3:    per_ms = `LRG_PER_MS_3;
            3'h4:    per_ms = `LRG_PER_MS_4;
            3'h5:    per_ms = `LRG_PER_MS_5;
            3'h6:    per_ms = `LRG_PER_MS_6;
            default: per_ms = cust_q;
        endcase
        if (full_speed)
        begin
            per_ms = `LRG_PER_MS_1;
        end
        // a zero custom period is treated as the shortest, one ms
        if (per_ms == 16'h0000)
        begin
            per_ms = `LRG_PER_MS_1;
        end
    end

    // ------------------------------------------------------------------------
    // millisecond time base
    // ------------------------------------------------------------------------

    // prescaler restarts whenever the execution stage is not waiting
    always_comb
    begin
        ms_tick = (pre_q == PW'(CYC_PER_MS - 1));
        pre_d   = ms_tick ? '0 : pre_q + PW'(1);
        if (st_q != lrg_pkg::LRG_ST_WAIT)
        begin
            pre_d = '0;
        end
    end

    // ------------------------------------------------------------------------
    // execution stage
    // ------------------------------------------------------------------------

    // delayed mode waits out the whole period, then fires once
    always_comb
    begin
        st_d  = st_q;
        ms_d  = ms_q;
        res_d = res_q;
        stb_d = 1'b0;
        chn_d = chn_q;
        case (st_q)
            // engine stopped: outputs hold their last value
            lrg_pkg::LRG_ST_HALT:
            begin
                if (cfg_q.run)
                begin
                    st_d = lrg_pkg::LRG_ST_WAIT;
                    ms_d = per_ms;
                end
            end
            // count milliseconds down; full speed skips the wait
            lrg_pkg::LRG_ST_WAIT:
            begin
                if (!cfg_q.run)
                begin
                    st_d = lrg_pkg::LRG_ST_HALT;
                end
                else if (cfg_q.chain)
                begin
                    chn_d = gate_res;
                end
                else if (full_speed)
                begin
                    st_d = lrg_pkg::LRG_ST_FIRE;
                end
                else if (ms_tick)
                begin
                    ms_d = ms_q - 16'h0001;
                    if (ms_q == 16'h0001)
                    begin
                        st_d = lrg_pkg::LRG_ST_FIRE;
                    end
                end
            end
            // period elapsed: hand the gate result to the output stage
            lrg_pkg::LRG_ST_FIRE:
            begin
                res_d = gate_res;
                stb_d = 1'b1;
                st_d  = cfg_q.run ? lrg_pkg::LRG_ST_WAIT : lrg_pkg::LRG_ST_HALT;
                ms_d  = per_ms;
            end
            default:
            begin
                st_d = lrg_pkg::LRG_ST_HALT;
            end
        endcase
        // chain output follows the gate each cycle in next-rule mode while run is set
        if (cfg_q.chain && cfg_q.run)
        begin
            chn_d = gate_res;
        end
    end

    // execution stage registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_q  <= lrg_pkg::LRG_ST_HALT;
            pre_q <= '0;
            ms_q  <= 16'h0000;
            res_q <= 1'b0;
            stb_q <= 1'b0;
            chn_q <= 1'b0;
        end
        else
        begin
            st_q  <= st_d;
            pre_q <= pre_d;
            ms_q  <= ms_d;
            res_q <= res_d;
            stb_q <= stb_d;
            chn_q <= chn_d;
        end
    end

    // ------------------------------------------------------------------------
    // output slots
    // ------------------------------------------------------------------------

    // slot 0 becomes the link to the following rule in next-rule mode
    always_comb
    begin
        link_d = cfg_q.chain;
    end

    // every slot sees the execution result and acts on true or false
    for (genvar s = 0; s < 3; s++)
    begin : g_slot
        always_comb
        begin
            sres_d[s] = res_q;
            sact_d[s] = cfg_q.out_slot_en[s] & ~(s == 0 && cfg_q.chain);
        end
    end

    // slot registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sres_q <= 3'h0;
            sact_q <= 3'h0;
            link_q <= 1'b0;
        end
        else
        begin
            sres_q <= sres_d;
            sact_q <= sact_d;
            link_q <= link_d;
        end
    end

    // ------------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------------

    // one wait state: answer at the second access cycle
    always_comb
    begin
        acc_addr  = {paddr[11:2], 2'h0};
        wr_acc    = psel & penable & pready_q & pwrite;
        pready_d  = psel & penable & ~pready_q;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (psel && penable && !pready_q)
        begin
            prdata_d = 32'h0000_0000;
            case (acc_addr)
                `LRG_OFS_CTRL:   prdata_d[`LRG_CTRL_OSL_HI:0] = cfg_q;
                `LRG_OFS_PERIOD: prdata_d[`LRG_PER_SEL_HI:0]  = per_q;
                `LRG_OFS_CUSTOM: prdata_d[`LRG_CUST_HI:0]     = cust_q;
                `LRG_OFS_STATUS:
                begin
                    prdata_d[0]     = gate_res;
                    prdata_d[1]     = res_q;
                    prdata_d[2]     = chn_q;
                    prdata_d[4:3]   = st_q;
                    prdata_d[31:16] = ms_q;
                end
                default:         pslverr_d = 1'b1;
            endcase
        end
    end

    // register writes take effect at the completing edge
    always_comb
    begin
        cfg_d  = cfg_q;
        per_d  = per_q;
        cust_d = cust_q;
        if (wr_acc)
        begin
            case (acc_addr)
                `LRG_OFS_CTRL:   cfg_d  = pwdata[`LRG_CTRL_OSL_HI:0];
                `LRG_OFS_PERIOD: per_d  = pwdata[`LRG_PER_SEL_HI:0];
                `LRG_OFS_CUSTOM: cust_d = pwdata[`LRG_CUST_HI:0];
                default:         cfg_d  = cfg_q;
            endcase
        end
    end

    // bus and configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q     <= `LRG_CTRL_RST;
            per_q     <= `LRG_PER_RST;
            cust_q    <= `LRG_CUST_RST;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            cfg_q     <= cfg_d;
            per_q     <= per_d;
            cust_q    <= cust_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign prdata                  = prdata_q;
    assign pready                  = pready_q;
    assign pslverr                 = pslverr_q;
    assign chain_to_following_rule = chn_q;
    assign exec_result             = res_q;
    assign exec_strobe             = stb_q;
    assign slot_result             = sres_q;
    assign slot_active             = sact_q;
    assign slot_is_link            = link_q;

endmodule : lrg_rule

//--- verif/lrg_rule_chk.sv
// concurrent checks on the ports of the logic rule block
`timescale 1ns/10ps

module lrg_rule_chk
#(
    parameter int CYC_PER_MS = 4  // cycles in one millisecond
)
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [2:0]  cond_in,
    input wire logic        prev_rule_in,
    input wire logic        chain_to_following_rule,
    input wire logic        exec_result,
    input wire logic        exec_strobe,
    input wire logic [2:0]  slot_result,
    input wire logic [2:0]  slot_active,
    input wire logic        slot_is_link
);
    // -------------------------------------------------------------------------
    // bus handshake
    // -------------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // setup phase of a transfer
    sequence apb_setup_s;
        psel && !penable;
    endsequence
    // first access cycle, answer not yet given
    sequence apb_wait_s;
        psel && penable && !pready;
    endsequence

    apb_answer_a: assert property (apb_setup_s |=> apb_wait_s ##1 pready) else $error("bus answer late");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
    ready_access_a: assert property (pready |-> psel && penable) else $error("ready outside access");
    err_with_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    err_data_zero_a: assert property (pslverr |-> prdata == 32'h0000_0000) else $error("refused read has data");
    // -------------------------------------------------------------------------
    // execution and output stage
    // -------------------------------------------------------------------------
    strobe_pulse_a: assert property (exec_strobe |=> !exec_strobe) else $error("strobe too long");
    result_hold_a: assert property ($changed(exec_result) |-> exec_strobe) else $error("result moved");
    slot_follow_a: assert property (slot_result == {3{$past(exec_result)}}) else $error("slot lag");
    link_slot_a: assert property (slot_is_link |-> !slot_active[0]) else $error("link slot busy");
endmodule : lrg_rule_chk

bind lrg_rule lrg_rule_chk #(.CYC_PER_MS(CYC_PER_MS)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cond_in(cond_in), .prev_rule_in(prev_rule_in),
    .chain_to_following_rule(chain_to_following_rule), .exec_result(exec_result), .exec_strobe(exec_strobe),
    .slot_result(slot_result), .slot_active(slot_active), .slot_is_link(slot_is_link));

//--- verif/lrg_rule_test.sv
// self-checking bench for the logic rule block
`timescale 1ns/10ps
`include "lrg_defs.svh"

module lrg_rule_test;
    // -------------------------------------------------------------------------
    // signals
    // -------------------------------------------------------------------------
    localparam int CYC = 4;        // short millisecond for simulation
    logic        pclk = 1'b0;       // bus clock
    logic        presetn = 1'b0;    // reset, active low
    logic        psel = 1'b0;       // bus select
    logic        penable = 1'b0;    // bus access phase
    logic        pwrite = 1'b0;     // bus direction
    logic [11:0] paddr = 12'h000;   // bus address
    logic [31:0] pwdata = 32'h0;    // bus write data
    logic [31:0] prdata;            // bus read data
    logic        pready;            // bus answer
    logic        pslverr;           // bus refusal
    logic [2:0]  cond_in = 3'h0;    // input conditions
    logic        prev_in = 1'b0;    // previous rule result
    logic        chain_out;         // link to following rule
    logic        exec_result;       // delivered result
    logic        exec_strobe;       // delivery pulse
    logic [2:0]  slot_result;       // slot values
    logic [2:0]  slot_active;       // slots in use
    logic        slot_is_link;      // slot 0 is link
    int          fails = 0;         // mismatches
    int          cmp_count = 0;     // comparisons

    lrg_rule #(.CYC_PER_MS(CYC)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cond_in(cond_in), .prev_rule_in(prev_in), .chain_to_following_rule(chain_out),
        .exec_result(exec_result), .exec_strobe(exec_strobe), .slot_result(slot_result),
        .slot_active(slot_active), .slot_is_link(slot_is_link));

    // clock of 8 ns
    initial
    begin
        forever #4 pclk = ~pclk;
    end
    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one bus transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    // control word in field order
    function automatic logic [31:0] cfg(input logic run, input logic [1:0] op, input logic ch,
                                        input logic [2:0] en, input logic pv, input logic [2:0] os);
        cfg = {21'h0, os, pv, en, ch, op, run};
    endfunction : cfg

    // gate result from enabled inputs only
    function automatic logic gexp(input logic [1:0] op, input logic [2:0] en, input logic [2:0] c);
        logic a;
        logic o;
        a = &(c | ~en);
        o = |(c & en);
        case (op)
            2'h0: gexp = a;
            2'h1: gexp = o;
            2'h2: gexp = !a;
            default: gexp = !o;
        endcase
    endfunction : gexp

    // cycles until the next delivery pulse
    task automatic strobe(output int n);
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (exec_strobe !== 1'b1 && n < 1000);
        if (n >= 1000)
        begin
            fails++;
            end_of_test();
        end
    endtask : strobe

    // configure halted, then start
    task automatic start(input logic [31:0] c);
        wr(`LRG_OFS_CTRL, c & 32'hFFFF_FFFE);
        wr(`LRG_OFS_CTRL, c);
    endtask : start
    // -------------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        apb(1'b0, `LRG_OFS_CTRL, 32'h0, r, e);
        check(r, 32'h0);
        apb(1'b0, `LRG_OFS_PERIOD, 32'h0, r, e);
        check(r, 32'h0);
        apb(1'b0, `LRG_OFS_CUSTOM, 32'h0, r, e);
        check(r, 32'h1);
        wr(`LRG_OFS_CUSTOM, 32'hFFFF_1234);
        apb(1'b0, `LRG_OFS_CUSTOM, 32'h0, r, e);
        check(r, 32'h0000_1234);
        apb(1'b0, 12'h010, 32'h0, r, e);
        check(r, 32'h0);
        check({31'h0, e}, 32'h1);
    endtask : t_regs

    // every operation over every input combination, some slots unused
    task automatic t_gates(input logic [2:0] en);
        int n;
        for (int op = 0; op < 4; op++)
        begin
            start(cfg(1'b1, op[1:0], 1'b0, en, 1'b0, 3'h7));
            for (int c = 0; c < 8; c++)
            begin
                cond_in <= c[2:0];
                strobe(n);
                strobe(n);
                check(exec_result, gexp(op[1:0], en, c[2:0]));
                check(n, 2);
            end
        end
    endtask : t_gates

    // delivery spacing for predefined and custom periods
    task automatic t_delay(input logic [2:0] sel, input logic [15:0] cust, input int ms);
        int n;
        wr(`LRG_OFS_CTRL, 32'h0);
        wr(`LRG_OFS_PERIOD, {29'h0, sel});
        wr(`LRG_OFS_CUSTOM, {16'h0, cust});
        start(cfg(1'b1, 2'h1, 1'b0, 3'h1, 1'b0, 3'h7));
        strobe(n);
        strobe(n);
        check(n, ms * CYC + 1);
    endtask : t_delay

    // next-rule mode forwards at once and takes slot 0
    task automatic t_chain();
        logic        e;
        logic [31:0] r;
        logic        er;
        wr(`LRG_OFS_CTRL, 32'h0);
        wr(`LRG_OFS_PERIOD, 32'h0);
        start(cfg(1'b1, 2'h1, 1'b1, 3'h1, 1'b0, 3'h7));
        e = exec_result;
        for (int v = 0; v < 2; v++)
        begin
            cond_in <= {2'h0, v[0]};
            repeat (3) @(posedge pclk);
            check(chain_out, v[0]);
            check(exec_result, e);
            check({slot_is_link, slot_active}, 4'hE);
        end
        // status: gate true, chain true, waiting, delivered result unchanged
        apb(1'b0, `LRG_OFS_STATUS, 32'h0, r, er);
        check({16'h0, r[15:0]}, {27'h0, 2'h1, 1'b1, e, 1'b1});
    endtask : t_chain

    // previous rule result as input slot 2
    task automatic t_prev();
        int n;
        start(cfg(1'b1, 2'h0, 1'b0, 3'h4, 1'b1, 3'h7));
        for (int v = 1; v >= 0; v--)
        begin
            prev_in <= v[0];
            strobe(n);
            strobe(n);
            check(exec_result, v[0]);
        end
    endtask : t_prev
    // -------------------------------------------------------------------------
    // verdict and sequence
    // -------------------------------------------------------------------------
    task automatic end_of_test();
        if (fails == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // watchdog well beyond the expected run
    initial
    begin
        #400000;
        fails++;
        end_of_test();
    end

    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_gates(3'h7);
        t_gates(3'h5);
        t_gates(3'h0);
        t_delay(3'h1, 16'h0001, 1);
        t_delay(3'h2, 16'h0001, 10);
        t_delay(3'h7, 16'h0003, 3);
        t_delay(3'h7, 16'h0000, 1);
        t_chain();
        t_prev();
        end_of_test();
    end
endmodule : lrg_rule_test
